// ---- rtl/general_timer_defs.vh ----
// register map, field positions, reset values and timing for the timer unit
`ifndef GENERAL_TIMER_DEFS_VH
`define GENERAL_TIMER_DEFS_VH

// timer index: aux_a, core, aux_b, fine_a, fine_b
`define IDX_AUX_A      0
`define IDX_CORE       1
`define IDX_AUX_B      2
`define IDX_FINE_A     3
`define IDX_FINE_B     4

// byte addresses: control at 0x00+4*idx, count at 0x20+4*idx
`define CTRL_BASE      6'h00
`define COUNT_BASE     6'h08
`define CAPTURE_RELOAD_REGISTER_WORD    6'h10
`define STATUS_WORD    6'h11

// control register fields
`define F_PS_HI        2
`define F_PS_LO        0
`define F_MODE_HI      4
`define F_MODE_LO      3
`define F_RUN          5
`define F_DOWN         6
`define F_EXTDIR       7
`define F_INV          8
`define F_LATCH_CLK    9
`define F_SPECIAL      10
`define F_RELOAD       11
`define F_TRIG_HI      13
`define F_TRIG_LO      12
`define F_OUT_EN       14

// basic modes
`define MODE_TIMER     2'b00
`define MODE_GATED     2'b01
`define MODE_COUNTER   2'b10
`define MODE_QUAD      2'b11

// trigger / capture source select
`define TRIG_PIN       2'b00
`define TRIG_RISE      2'b01
`define TRIG_FALL      2'b10
`define TRIG_BOTH      2'b11

// finest resolution in system clocks, as a power of two
`define M1_RES_CYC     4
`define M1_RES_SHIFT   4'd2
`define M2_RES_CYC     2
`define M2_RES_SHIFT   4'd1

// reset values
`define CTRL_RST       16'h0000
`define COUNT_RST      16'h0000
`define ALL_ONES       16'hffff

`endif

// ---- rtl/general_timer_unit.v ----
// five-timer unit in two modules with a classic wishbone register slave
`timescale 1ns/1ps
`include "general_timer_defs.vh"

// What this block does
// - five 16-bit timers, three plus two
// - timers chain to partners within their module
// - first module: timer, gated, counter, quadrature
// - timer counts prescaled clock, counter counts pin
// - gated mode counts only while gate enables
// - first module resolution is four clocks
// - software direction, optionally altered by pin
// - quadrature derives count and direction from A/B
// - core latch toggles on wrap, clocks aux
// - aux in capture/reload role stops counting
// - aux pin edge captures core count
// - core reloads from aux on pin/latch edge
// - alternate aux reloads make free-running PWM
// - second module resolution is two clocks
// - fine timers count prescaled clock or pin
// - fine latch toggles on wrap, clocks fine_a
// - fine_b wrap clocks capcom, reloads from capreg
// - capture pin copies fine_a, optional clear
// - core pins may trigger that capture instead
module general_timer_unit (
    // clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // wishbone slave
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    // timer pins, one bit per timer index
    input  wire [4:0]  timer_input_pin_i,
    input  wire [4:0]  timer_direction_pin_i,
    input  wire        capture_pin_i,
    // outputs
    output reg         core_toggle_output_o,
    output reg         fine_toggle_output_o,
    output reg         capcom_clock_o
);

    // storage layout: one control word and one count word per timer
    // index order is aux_a, core, aux_b, fine_a, fine_b throughout
    // the capture/reload word belongs to the second module only
    // both toggle latches are readable and writable through status
    // the free prescaler counter never stops and is never written,
    // so every timer tick is aligned to it and two timers with the
    // same prescale setting in one module always tick in the same cycle
    // pin history registers give edges one cycle after a change;
    // they are cleared by reset, so a pin that sits high when
    // reset ends is seen as a rising edge at the first clock
    // register storage
    reg  [15:0] ctrl [0:4];          // per-timer control
    reg  [15:0] cnt  [0:4];          // per-timer count
    reg  [15:0] capture_reload_register; // capture/reload word
    reg         core_toggle_latch;   // core wrap latch
    reg         fine_toggle_latch;   // fine_b wrap latch
    reg         core_latch_prev;     // for latch edges
    reg         fine_latch_prev;     // for latch edges
    reg  [15:0] pre;                 // free prescaler counter
    reg  [4:0]  in_prev;             // previous input pins
    reg  [4:0]  dir_prev;            // previous direction pins
    reg         cap_prev;            // previous capture pin

    // per-timer combinational results
    wire [4:0]  en;                  // count this cycle
    wire [4:0]  dn;                  // count down
    wire [4:0]  ovf;                 // wrap this cycle
    wire [4:0]  pin_rise;            // qualified pin edge
    wire [4:0]  rel_req;             // aux asks to reload core
    wire [4:0]  cap_req;             // aux asks to capture core
    wire [79:0] step;                // counted values

    // latch transitions
    wire core_rise = core_toggle_latch & ~core_latch_prev;
    wire core_fall = ~core_toggle_latch & core_latch_prev;
    wire core_chg  = core_toggle_latch ^ core_latch_prev;
    wire fine_chg  = fine_toggle_latch ^ fine_latch_prev;

    // low k bits set
    function [15:0] low_mask;
        input [3:0] k;
        begin
            low_mask = (16'h0001 << k) - 16'h0001;
        end
    endfunction

    // byte-lane merge for 16-bit registers
    function [15:0] merge;
        input [15:0] old;
        input [15:0] nw;
        input [1:0]  sel;
        begin
            merge = {sel[1] ? nw[15:8] : old[15:8],
                     sel[0] ? nw[7:0]  : old[7:0]};
        end
    endfunction

    // each slice works out, for its own index only:
    //  - whether it counts in this cycle (en)
    //  - which way it counts (dn)
    //  - whether the count wraps in this cycle (ovf)
    //  - the value it would hold after one step (step)
    //  - capture and reload requests when it plays an aux role
    // the slice never writes a register itself; the one clocked
    // process below applies every request, so priority between
    // bus, capture, reload and counting is decided in one place
    // mode decode for the second module ignores quadrature, which
    // falls back to plain pin counting there
    // chaining through a latch is offered to aux_a, aux_b, fine_a
    // one timer slice per index
    genvar i;
    generate
        for (i = 0; i < 5; i = i + 1) begin : g_tmr
            wire [15:0] c  = ctrl[i];
            wire [1:0]  md = c[`F_MODE_HI:`F_MODE_LO];
            wire [1:0]  tr = c[`F_TRIG_HI:`F_TRIG_LO];
            // prescaled tick, base shift per module
            wire [3:0]  k  = {1'b0, c[`F_PS_HI:`F_PS_LO]} +
                             ((i < 3) ? `M1_RES_SHIFT : `M2_RES_SHIFT);
            wire        tick = (pre & low_mask(k)) == low_mask(k);
            wire        lvl  = timer_input_pin_i[i] ^ c[`F_INV];
            wire        plv  = in_prev[i] ^ c[`F_INV];
            wire        a_chg = timer_input_pin_i[i] ^ in_prev[i];
            wire        b_chg = timer_direction_pin_i[i] ^ dir_prev[i];
            // concatenation source: core latch for aux, fine latch for fine_a
            wire        l_chg = (i == `IDX_FINE_A) ? fine_chg : core_chg;
            wire        can_chain = (i != `IDX_CORE) && (i != `IDX_FINE_B);
            wire        special = ((i == `IDX_AUX_A) || (i == `IDX_AUX_B))
                                  && c[`F_SPECIAL];
            wire        quad = (i < 3) && (md == `MODE_QUAD);
            reg         ev;
            // count event by mode
            always @* begin
                case (md)
                    `MODE_TIMER:   ev = tick;
                    `MODE_GATED:   ev = tick & lvl;
                    `MODE_COUNTER: ev = (can_chain && c[`F_LATCH_CLK]) ?
                                        l_chg : (lvl & ~plv);
                    default:       ev = quad ? (a_chg | b_chg) :
                                        (lvl & ~plv);
                endcase
            end
            assign pin_rise[i] = lvl & ~plv;
            // stopped while acting as capture/reload register
            assign en[i] = c[`F_RUN] & ~special & ev;
            // direction: software bit, inverted by pin, or quadrature phase
            assign dn[i] = quad ?
                ~(timer_input_pin_i[i] ^ dir_prev[i]) ^ c[`F_DOWN] :
                c[`F_DOWN] ^ (c[`F_EXTDIR] & timer_direction_pin_i[i]);
            assign ovf[i] = en[i] & (dn[i] ? (cnt[i] == `COUNT_RST) :
                                             (cnt[i] == `ALL_ONES));
            assign step[i*16 +: 16] = dn[i] ? cnt[i] - 16'h0001 :
                                              cnt[i] + 16'h0001;
            // aux capture and reload requests
            assign cap_req[i] = special & ~c[`F_RELOAD] & pin_rise[i];
            assign rel_req[i] = special & c[`F_RELOAD] &
                ((tr == `TRIG_PIN)  ? pin_rise[i] :
                 (tr == `TRIG_RISE) ? core_rise :
                 (tr == `TRIG_FALL) ? core_fall : core_chg);
        end
    endgenerate

    // capture into the capture/reload word is edge based on both
    // directions of the chosen pin, unlike aux capture which only
    // takes the rising edge of the possibly inverted input
    // the core pins as source suit a core in quadrature use,
    // where each sensor step then records the fine_a time stamp
    // source codes 1 and 2 reuse the trigger field of fine_a
    // fine_a capture source select
    wire [15:0] fa_c = ctrl[`IDX_FINE_A];
    wire [1:0]  fa_src = fa_c[`F_TRIG_HI:`F_TRIG_LO];
    wire        cap_edge = capture_pin_i ^ cap_prev;
    wire        core_in_edge = timer_input_pin_i[`IDX_CORE] ^
                               in_prev[`IDX_CORE];
    wire        core_dir_edge = timer_direction_pin_i[`IDX_CORE] ^
                                dir_prev[`IDX_CORE];
    reg         fine_cap;            // capture fine_a this cycle
    // capture trigger selection
    always @* begin
        case (fa_src)
            `TRIG_PIN:  fine_cap = cap_edge;
            `TRIG_RISE: fine_cap = core_in_edge;
            `TRIG_FALL: fine_cap = core_dir_edge;
            default:    fine_cap = core_in_edge | core_dir_edge;
        endcase
    end

    // the slave answers every request one cycle after it is taken;
    // the ack itself masks the request in its own cycle, so a
    // master that holds stb one cycle longer is not served twice
    // only the low two byte lanes matter, registers are 16 bits
    // reads return the value before any update at the same edge
    // bus decode
    wire        bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [5:0]  word = wb_adr_i[7:2];
    wire        wr = bus_req & wb_we_i;
    reg  [15:0] rd;                  // read mux

    // read mux; unmapped words read zero
    always @* begin
        rd = 16'h0000;
        if (word < 6'd5) begin
            rd = ctrl[word[2:0]];
        end else if ((word >= `COUNT_BASE) && (word < 6'd13)) begin
            rd = cnt[word[2:0]];
        end else if (word == `CAPTURE_RELOAD_REGISTER_WORD) begin
            rd = capture_reload_register;
        end else if (word == `STATUS_WORD) begin
            rd = {14'h0000, fine_toggle_latch, core_toggle_latch};
        end
    end

    // everything clocked lives in this one process so that each
    // register has a single driver and a clear priority order:
    // later assignments in the process win over earlier ones
    // order of precedence, lowest first:
    //  counting, aux capture, core reload, fine_b reload,
    //  fine_a capture and clear, software write
    // reset is synchronous and loads constants only
    // main sequential process
    integer j;
    always @(posedge clk_i) begin
        if (rst_i) begin
            for (j = 0; j < 5; j = j + 1) begin
                ctrl[j] <= `CTRL_RST;
                cnt[j]  <= `COUNT_RST;
            end
            capture_reload_register <= `COUNT_RST;
            core_toggle_latch       <= 1'b0;
            fine_toggle_latch       <= 1'b0;
            core_latch_prev         <= 1'b0;
            fine_latch_prev         <= 1'b0;
            pre                     <= 16'h0000;
            in_prev                 <= 5'h00;
            dir_prev                <= 5'h00;
            cap_prev                <= 1'b0;
            wb_ack_o                <= 1'b0;
            wb_dat_o                <= 32'h00000000;
            core_toggle_output_o    <= 1'b0;
            fine_toggle_output_o    <= 1'b0;
            capcom_clock_o          <= 1'b0;
        end else begin
            // history for edge detection (pins already synchronous)
            pre      <= pre + 16'h0001;
            in_prev  <= timer_input_pin_i;
            dir_prev <= timer_direction_pin_i;
            cap_prev <= capture_pin_i;
            core_latch_prev <= core_toggle_latch;
            fine_latch_prev <= fine_toggle_latch;

            // each timer steps by one when its slice says so; the
            // wrap needs no extra handling because the 16-bit sum
            // rolls over by itself
            // counting
            for (j = 0; j < 5; j = j + 1) begin
                if (en[j]) begin
                    cnt[j] <= step[j*16 +: 16];
                end
            end

            // aux capture of core, core reload from aux
            if (cap_req[`IDX_AUX_A]) begin
                cnt[`IDX_AUX_A] <= cnt[`IDX_CORE];
            end
            if (cap_req[`IDX_AUX_B]) begin
                cnt[`IDX_AUX_B] <= cnt[`IDX_CORE];
            end
            if (rel_req[`IDX_AUX_A]) begin
                cnt[`IDX_CORE] <= cnt[`IDX_AUX_A];
            end else if (rel_req[`IDX_AUX_B]) begin
                cnt[`IDX_CORE] <= cnt[`IDX_AUX_B];
            end

            // fine_b wrap reloads from the capture/reload word
            if (ovf[`IDX_FINE_B] && ctrl[`IDX_FINE_B][`F_SPECIAL]) begin
                cnt[`IDX_FINE_B] <= capture_reload_register;
            end

            // fine_a capture, optional clear
            if (fine_cap) begin
                capture_reload_register <= cnt[`IDX_FINE_A];
                if (fa_c[`F_SPECIAL]) begin
                    cnt[`IDX_FINE_A] <= `COUNT_RST;
                end
            end

            // bus writes override hardware updates of the same word
            if (wr) begin
                if (word < 6'd5) begin
                    ctrl[word[2:0]] <= merge(ctrl[word[2:0]],
                                             wb_dat_i[15:0], wb_sel_i[1:0]);
                end else if ((word >= `COUNT_BASE) && (word < 6'd13)) begin
                    cnt[word[2:0]] <= merge(cnt[word[2:0]],
                                            wb_dat_i[15:0], wb_sel_i[1:0]);
                end else if (word == `CAPTURE_RELOAD_REGISTER_WORD) begin
                    capture_reload_register <=
                        merge(capture_reload_register,
                              wb_dat_i[15:0], wb_sel_i[1:0]);
                end
            end

            // latches: wrap toggle applied on top of a software write
            if (wr && (word == `STATUS_WORD) && wb_sel_i[0]) begin
                core_toggle_latch <= wb_dat_i[0] ^ ovf[`IDX_CORE];
                fine_toggle_latch <= wb_dat_i[1] ^ ovf[`IDX_FINE_B];
            end else begin
                core_toggle_latch <= core_toggle_latch ^ ovf[`IDX_CORE];
                fine_toggle_latch <= fine_toggle_latch ^ ovf[`IDX_FINE_B];
            end

            // pin outputs and capcom clock pulse
            core_toggle_output_o <= core_toggle_latch &
                                    ctrl[`IDX_CORE][`F_OUT_EN];
            fine_toggle_output_o <= fine_toggle_latch &
                                    ctrl[`IDX_FINE_B][`F_OUT_EN];
            capcom_clock_o <= ovf[`IDX_FINE_B];

            // read data is captured with the ack and then stands
            // until the next request is answered
            // wishbone answer, one wait state
            wb_ack_o <= bus_req;
            if (bus_req) begin
                wb_dat_o <= {16'h0000, rd};
            end
        end
    end

endmodule

// ---- tb/ext_pin_model.sv ----
// external pins: sensors, gates, count and capture signals
`timescale 1ns/1ps
module ext_pin_model (
    // clock
    input  wire       clk_i,
    // pins toward the timer unit
    output reg  [4:0] input_pin_o,
    output reg  [4:0] dir_pin_o,
    output reg        capture_o
);
    // all pins idle low
    initial begin
        input_pin_o = 5'h00;
        dir_pin_o   = 5'h00;
        capture_o   = 1'b0;
    end
    // flip one pin just after an edge, then rest for gap edges
    task automatic flip(input int kind, input int idx, input int gap);
        @(posedge clk_i);
        if (kind == 0)
            input_pin_o[idx] <= ~input_pin_o[idx];
        else if (kind == 1)
            dir_pin_o[idx] <= ~dir_pin_o[idx];
        else
            capture_o <= ~capture_o;
        repeat (gap) @(posedge clk_i);
    endtask
endmodule

// ---- tb/test_general_timer_unit.sv ----
// self-checking bench for the five-timer unit
`timescale 1ns/1ps
module test_general_timer_unit;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, cap_pin, core_out, fine_out, capcom_clk;
    wire  [4:0]  in_pins, dir_pins;
    int          err_total, n_tests, k, n_tog;
    logic        p_out;
    logic [15:0] q;
    general_timer_unit dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .timer_input_pin_i(in_pins), .timer_direction_pin_i(dir_pins),
        .capture_pin_i(cap_pin), .core_toggle_output_o(core_out),
        .fine_toggle_output_o(fine_out), .capcom_clock_o(capcom_clk));
    ext_pin_model pm (.clk_i(clk_i), .input_pin_o(in_pins),
        .dir_pin_o(dir_pins), .capture_o(cap_pin));
    // 50 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task give_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // one classic bus cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] r);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= a;
        wb_dat_i <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) begin
            err_total++;
            give_verdict;
        end
        r = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] x;
        wb(1'b1, a, d, x);
    endtask
    task rd(input logic [7:0] a, output logic [15:0] r);
        wb(1'b0, a, 16'h0000, r);
    endtask
    task pulse(input int idx);
        pm.flip(0, idx, 1);
        pm.flip(0, idx, 1);
    endtask
    // ticks over a 40-cycle window between two reads
    task rate_one(input logic [7:0] c, input logic [15:0] m, e);
        logic [15:0] a;
        wr(c + 8'h20, 16'h0000);
        wr(c, m);
        rd(c + 8'h20, a);
        repeat (37) @(posedge clk_i);
        rd(c + 8'h20, q);
        chk("tick delta", q - a, e);
        wr(c, 16'h0000);
    endtask
    initial begin
        err_total = 0;
        n_tests = 0;
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hf;
        wb_dat_i = 32'h0;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        // reset values and an unmapped word
        rd(8'h24, q);
        chk("core count", q, 16'h0000);
        wr(8'h50, 16'h1234);
        rd(8'h50, q);
        chk("unmapped word", q, 16'h0000);
        $display("test reset done");
        // wrap up and down with the core latch on its pin
        wr(8'h24, 16'hffff);
        wr(8'h04, 16'h4030);
        pulse(1);
        rd(8'h24, q);
        chk("wrap up", q, 16'h0000);
        rd(8'h44, q);
        chk("latch set", q, 16'h0001);
        chk("core pin", {15'h0, core_out}, 16'h0001);
        wr(8'h04, 16'h4070);
        pulse(1);
        rd(8'h24, q);
        chk("wrap down", q, 16'hffff);
        chk("core pin", {15'h0, core_out}, 16'h0000);
        $display("test wrap done");
        // counter mode with software and pin direction
        wr(8'h24, 16'h0000);
        wr(8'h04, 16'h0030);
        repeat (3) pulse(1);
        rd(8'h24, q);
        chk("count up", q, 16'h0003);
        wr(8'h04, 16'h00b0);
        pm.flip(1, 1, 1);
        repeat (2) pulse(1);
        rd(8'h24, q);
        chk("pin direction", q, 16'h0001);
        pm.flip(1, 1, 1);
        wr(8'h04, 16'h0070);
        pulse(1);
        rd(8'h24, q);
        chk("soft direction", q, 16'h0000);
        $display("test counter done");
        // timer rates at both resolutions, gated rate at the first module resolution
        rate_one(8'h04, 16'h0020, 16'd10);
        rate_one(8'h0c, 16'h0020, 16'd20);
        rate_one(8'h04, 16'h0028, 16'd0);
        pm.flip(0, 1, 1);
        rate_one(8'h04, 16'h0028, 16'd10);
        pm.flip(0, 1, 1);
        $display("test rate done");
        // quadrature forward then backward
        wr(8'h24, 16'h0000);
        wr(8'h04, 16'h0038);
        for (k = 0; k < 4; k++)
            pm.flip(k % 2, 1, 1);
        rd(8'h24, q);
        chk("quad forward", q, 16'h0004);
        for (k = 0; k < 4; k++)
            pm.flip(1 - k % 2, 1, 1);
        rd(8'h24, q);
        chk("quad back", q, 16'h0000);
        wr(8'h04, 16'h0000);
        $display("test quadrature done");
        // aux capture of the stopped core
        wr(8'h24, 16'h1234);
        wr(8'h00, 16'h0420);
        pulse(0);
        rd(8'h20, q);
        chk("aux capture", q, 16'h1234);
        repeat (20) @(posedge clk_i);
        rd(8'h20, q);
        chk("aux stopped", q, 16'h1234);
        wr(8'h00, 16'h0000);
        wr(8'h28, 16'habcd);
        wr(8'h08, 16'h0c00);
        pulse(2);
        rd(8'h24, q);
        chk("pin reload", q, 16'habcd);
        wr(8'h08, 16'h0000);
        $display("test capture done");
        // fine capture with clear, then from the core pin
        wr(8'h2c, 16'h0055);
        wr(8'h0c, 16'h0400);
        pm.flip(2, 0, 1);
        rd(8'h40, q);
        chk("fine capture", q, 16'h0055);
        rd(8'h2c, q);
        chk("fine cleared", q, 16'h0000);
        wr(8'h2c, 16'h0066);
        wr(8'h0c, 16'h1400);
        pm.flip(0, 1, 1);
        rd(8'h40, q);
        chk("core pin capture", q, 16'h0066);
        wr(8'h0c, 16'h0000);
        pm.flip(0, 1, 1);
        $display("test fine capture done");
        // fine_b wrap: capcom clock, latch pin, reload
        wr(8'h40, 16'h8000);
        wr(8'h30, 16'hfff0);
        wr(8'h0c, 16'h0230);
        wr(8'h10, 16'h4420);
        for (k = 0; k < 200 && capcom_clk !== 1'b1; k++)
            @(posedge clk_i);
        chk("capcom clock", {15'h0, capcom_clk}, 16'h0001);
        repeat (2) @(posedge clk_i);
        chk("fine pin", {15'h0, fine_out}, 16'h0001);
        rd(8'h30, q);
        chk("reload", {15'h0, q - 16'h8000 < 16'h0020}, 16'h0001);
        wr(8'h10, 16'h0000);
        rd(8'h44, q);
        chk("fine latch", q, 16'h0002);
        rd(8'h2c, q);
        chk("fine chain", q, 16'h0001);
        wr(8'h0c, 16'h0000);
        $display("test fine wrap done");
        // both aux reload the core on opposite latch edges
        wr(8'h20, 16'hfff8);
        wr(8'h28, 16'hfff8);
        wr(8'h24, 16'hfff8);
        wr(8'h00, 16'h1c00);
        wr(8'h08, 16'h2c00);
        wr(8'h04, 16'h4020);
        n_tog = 0;
        p_out = core_out;
        for (k = 0; k < 300; k++) begin
            @(posedge clk_i);
            if (core_out !== p_out) begin
                n_tog++;
                p_out = core_out;
            end
        end
        chk("pwm toggles", {15'h0, n_tog >= 6}, 16'h0001);
        rd(8'h24, q);
        chk("pwm range", {15'h0, q >= 16'hfff8 || q == 16'h0}, 16'h0001);
        wr(8'h04, 16'h0000);
        $display("test pwm done");
        give_verdict;
    end
endmodule

// ---- tb/timer_unit_checker_asserts.sv ----
// port-level assertions for the five-timer unit
`timescale 1ns/1ps
module timer_unit_checker (
    // clock and reset
    input wire        clk_i,
    input wire        rst_i,
    // register bus
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    // pins and outputs
    input wire [4:0]  timer_input_pin_i,
    input wire [4:0]  timer_direction_pin_i,
    input wire        capture_pin_i,
    input wire        core_toggle_output_o,
    input wire        fine_toggle_output_o,
    input wire        capcom_clock_o
);
    // one clock domain, synchronous reset
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_upper_zero: assert property (
        wb_dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_data_with_ack: assert property (
        $changed(wb_dat_o) && !$past(rst_i) |-> wb_ack_o)
        else $error("read data moved without ack");
    a_status_bits: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i[7:2] == 6'h11)
        |-> wb_dat_o[15:2] == 14'h0000)
        else $error("status holds extra bits");
    a_unmapped_zero: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i >= 8'h48) |-> wb_dat_o == 0)
        else $error("unmapped read not zero");
    a_capcom_single: assert property (
        capcom_clock_o |=> !capcom_clock_o)
        else $error("capcom clock pulse too wide");
    a_outs_cleared: assert property (
        $fell(rst_i) |-> !core_toggle_output_o && !fine_toggle_output_o
        && !capcom_clock_o && !wb_ack_o)
        else $error("outputs not cleared by reset");
    // main scenarios reached
    c_core_out: cover property ($rose(core_toggle_output_o));
    c_fine_out: cover property ($rose(fine_toggle_output_o));
    c_capcom: cover property (capcom_clock_o);
endmodule

bind general_timer_unit timer_unit_checker chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .timer_input_pin_i(timer_input_pin_i),
    .timer_direction_pin_i(timer_direction_pin_i),
    .capture_pin_i(capture_pin_i), .capcom_clock_o(capcom_clock_o),
    .core_toggle_output_o(core_toggle_output_o),
    .fine_toggle_output_o(fine_toggle_output_o));
